// >>> src/hpsd_pkg.sv
package hpsd_pkg;
   // ==========================================
   // access type codes
   typedef enum logic [1:0] {
      HPSD_ACC_CTRL     = 2'h0,
      HPSD_ACC_DATA_INC = 2'h1,
      HPSD_ACC_ADDR     = 2'h2,
      HPSD_ACC_DATA     = 2'h3
   } hpsd_acc_t;

   // ==========================================
   // control register layout and reset values
   localparam int          HPSD_CTRL_ORDER_BIT  = 0;
   localparam int          HPSD_CTRL_MIRROR_BIT = 8;
   localparam logic [15:0] HPSD_CTRL_RST        = 16'h0000;
   localparam logic [31:0] HPSD_ADDR_RST        = 32'h0000_0000;
   localparam logic [31:0] HPSD_DATA_RST        = 32'h0000_0000;
   localparam logic [31:0] HPSD_ADDR_STEP       = 32'h0000_0001;
   localparam logic [2:0]  HPSD_SYNC_RST        = 3'h7;
endpackage

// >>> src/hpsd_sync.sv
`timescale 1ns/100ps
`default_nettype none
module hpsd_sync
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // asynchronous level in, filtered level out
   input  wire logic async_in,
   output var  logic level_out
);
   logic [2:0] shift_r;

   // ==========================================
   // three stages; change accepted once stages two and three agree
   always_ff @(posedge mclk)
   begin
      if (reset)
         shift_r <= hpsd_pkg::HPSD_SYNC_RST;
      else
         shift_r <= {shift_r[1:0], async_in};
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         level_out <= 1'b1;
      else if (shift_r[1] == shift_r[2])
         level_out <= shift_r[2];
   end
endmodule
`default_nettype wire

// >>> src/hpsd_top.sv
// Summary of operation
// [R1] - data strobe activity ignored while port_select_n is high
// [R2] - internal strobe low when selected and the two data strobes differ
// [R3] - wait_ready_n forced low whenever port_select_n is high
// [R4] - single active-low host strobe: other strobe input held high
// [R5] - single active-high host strobe: other strobe input held low
// [R6] - separate read/write strobes: direction supplied by other host line
// [R7] - select and a strobe may share one host signal; ready still gated
// [R8] - host should not use select as the strobe with static strobes
// [R9] - access code: 00 control, 01 data inc, 10 address, 11 data
// [R10] - data access with autoincrement bumps address by one word after
// [R11] - direction high reads, low writes; eight cycle types in all
// [R12] - code latched on address strobe fall, else internal strobe fall
// [R13] - 16-bit mode: two halfword transfers, code presented on each
// [R14] - halfword_ident low on first, high on second transfer
// [R15] - halfword_order picks which half is most significant
// [R16] - halfword_order written at bit 0, read back at bits 0 and 8
// [R17] - 16-bit control access: single halfword, same value either half
// [R18] - 32-bit mode ignores halfword_ident, one word per strobe
// [R19] - host waits for ready low before ending strobe
// [R20] - bus_width_strap high at reset 32-bit, low 16-bit
// [R21] - write data latched into data register on strobe rising edge
`timescale 1ns/100ps
`default_nettype none
module hpsd_top
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // host pins
   input  wire logic        port_select_n,
   input  wire logic        data_strobe_a,
   input  wire logic        data_strobe_b,
   input  wire logic        addr_strobe_n,
   input  wire logic [1:0]  access_type_code,
   input  wire logic        rd_wr_dir,
   input  wire logic        halfword_ident,
   input  wire logic        bus_width_strap,
   input  wire logic [31:0] host_data_in,
   output logic      [31:0] host_data_out,
   output logic             host_data_oe,
   output logic             wait_ready_n,
   // back end
   input  wire logic        core_busy,
   input  wire logic [31:0] core_rd_data,
   output logic             mux32_mode,
   output logic             halfword_order,
   output logic      [31:0] read_addr_reg,
   output logic      [31:0] write_addr_reg,
   output logic      [31:0] port_data_reg,
   output logic             data_wr_pulse,
   output logic             data_rd_pulse
);
   // ==========================================
   // pin synchronisers
   logic cs_s, dsa_s, dsb_s, as_s;

   hpsd_sync u_cs  (.mclk(mclk), .reset(reset), .async_in(port_select_n), .level_out(cs_s));
   hpsd_sync u_dsa (.mclk(mclk), .reset(reset), .async_in(data_strobe_a), .level_out(dsa_s));
   hpsd_sync u_dsb (.mclk(mclk), .reset(reset), .async_in(data_strobe_b), .level_out(dsb_s));
   hpsd_sync u_as  (.mclk(mclk), .reset(reset), .async_in(addr_strobe_n), .level_out(as_s));

   // ==========================================
   // internal strobe
   logic internal_strobe_n, strobe_nxt;
   logic as_r;
   logic fall_d_r;

   // selected and strobes differ; select high masks both data strobes
   assign strobe_nxt = ~(~cs_s & (dsa_s ^ dsb_s)); // [R1] [R2]

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         internal_strobe_n <= 1'b1;
         as_r              <= 1'b1;
         fall_d_r          <= 1'b0;
      end
      else
      begin
         internal_strobe_n <= strobe_nxt;
         as_r              <= as_s;
         fall_d_r          <= internal_strobe_n & ~strobe_nxt;
      end
   end

   wire strobe_fall = internal_strobe_n & ~strobe_nxt;
   wire strobe_rise = ~internal_strobe_n & strobe_nxt;
   wire as_fall     = as_r & ~as_s;

   // ==========================================
   // width strap caught at release of reset
   logic strap_taken_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         strap_taken_r <= 1'b0;
         mux32_mode    <= 1'b1;
      end
      else if (!strap_taken_r)
      begin
         strap_taken_r <= 1'b1;
         mux32_mode    <= bus_width_strap; // [R20]
      end
   end

   // ==========================================
   // cycle type latch
   // pins held stable by the host around the strobe edges, so read directly
   hpsd_pkg::hpsd_acc_t acc_r;
   logic                dir_r;
   logic                hw_r;
   logic                as_latched_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         acc_r        <= hpsd_pkg::HPSD_ACC_CTRL;
         dir_r        <= 1'b1;
         hw_r         <= 1'b0;
         as_latched_r <= 1'b0;
      end
      else if (as_fall)
      begin
         acc_r        <= hpsd_pkg::hpsd_acc_t'(access_type_code); // [R9] [R12]
         dir_r        <= rd_wr_dir; // [R11]
         hw_r         <= halfword_ident;
         as_latched_r <= 1'b1;
      end
      else if (strobe_fall && !as_latched_r)
      begin
         acc_r <= hpsd_pkg::hpsd_acc_t'(access_type_code); // [R12]
         dir_r <= rd_wr_dir;
         hw_r  <= halfword_ident;
      end
      else if (strobe_rise)
         as_latched_r <= 1'b0;
   end

   // ==========================================
   // halfword helpers
   // msb-first when order bit clear; true when this transfer carries the upper half
   function automatic logic is_upper(input logic order, input logic second);
      is_upper = order ? second : ~second; // [R15]
   endfunction

   function automatic logic [31:0] put_half(input logic [31:0] word, input logic upper,
                                            input logic [15:0] half);
      put_half = upper ? {half, word[15:0]} : {word[31:16], half};
   endfunction

   function automatic logic [15:0] get_half(input logic [31:0] word, input logic upper);
      get_half = upper ? word[31:16] : word[15:0];
   endfunction

   // ==========================================
   // cycle decode
   wire is_data  = (acc_r == hpsd_pkg::HPSD_ACC_DATA) || (acc_r == hpsd_pkg::HPSD_ACC_DATA_INC);
   wire is_inc   = (acc_r == hpsd_pkg::HPSD_ACC_DATA_INC);
   wire is_addr  = (acc_r == hpsd_pkg::HPSD_ACC_ADDR);
   wire is_ctrl  = (acc_r == hpsd_pkg::HPSD_ACC_CTRL);
   // whole word done: every strobe in 32-bit, second half in 16-bit
   wire word_end = mux32_mode | hw_r; // [R13] [R14] [R18]
   wire upper    = is_upper(halfword_order, hw_r);

   // ==========================================
   // control register
   always_ff @(posedge mclk)
   begin
      if (reset)
         halfword_order <= hpsd_pkg::HPSD_CTRL_RST[hpsd_pkg::HPSD_CTRL_ORDER_BIT];
      else if (strobe_rise && is_ctrl && !dir_r)
         halfword_order <= host_data_in[hpsd_pkg::HPSD_CTRL_ORDER_BIT]; // [R16] [R17]
   end

   logic [15:0] ctrl_view;
   always_comb
   begin
      ctrl_view = hpsd_pkg::HPSD_CTRL_RST;
      ctrl_view[hpsd_pkg::HPSD_CTRL_ORDER_BIT]  = halfword_order; // [R16]
      ctrl_view[hpsd_pkg::HPSD_CTRL_MIRROR_BIT] = halfword_order;
   end

   // ==========================================
   // address registers (single-register behaviour on host writes)
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         read_addr_reg  <= hpsd_pkg::HPSD_ADDR_RST;
         write_addr_reg <= hpsd_pkg::HPSD_ADDR_RST;
      end
      else if (strobe_rise && is_addr && !dir_r)
      begin
         if (mux32_mode)
         begin
            read_addr_reg  <= host_data_in; // [R18]
            write_addr_reg <= host_data_in;
         end
         else
         begin
            read_addr_reg  <= put_half(read_addr_reg, upper, host_data_in[15:0]);
            write_addr_reg <= put_half(write_addr_reg, upper, host_data_in[15:0]);
         end
      end
      else if (strobe_rise && is_inc && word_end)
      begin
         // single mode: both copies advance together, after the access has completed
         read_addr_reg  <= read_addr_reg + hpsd_pkg::HPSD_ADDR_STEP; // [R10]
         write_addr_reg <= write_addr_reg + hpsd_pkg::HPSD_ADDR_STEP; // [R10]
      end
   end

   // ==========================================
   // data register
   always_ff @(posedge mclk)
   begin
      if (reset)
         port_data_reg <= hpsd_pkg::HPSD_DATA_RST;
      else if (strobe_rise && is_data && !dir_r)
         port_data_reg <= mux32_mode ? host_data_in
                        : put_half(port_data_reg, upper, host_data_in[15:0]); // [R21]
      // one cycle after the fall, so the freshly latched cycle type decides
      else if (fall_d_r && is_data && dir_r && (mux32_mode || !hw_r))
         port_data_reg <= core_rd_data;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         data_wr_pulse <= 1'b0;
         data_rd_pulse <= 1'b0;
      end
      else
      begin
         data_wr_pulse <= strobe_rise & is_data & ~dir_r & word_end;
         data_rd_pulse <= strobe_rise & is_data & dir_r & word_end;
      end
   end

   // ==========================================
   // read data drive
   logic [31:0] rd_word;
   always_comb
   begin
      case (acc_r)
         hpsd_pkg::HPSD_ACC_CTRL:     rd_word = {ctrl_view, ctrl_view}; // [R17]
         hpsd_pkg::HPSD_ACC_ADDR:     rd_word = read_addr_reg;
         hpsd_pkg::HPSD_ACC_DATA,
         hpsd_pkg::HPSD_ACC_DATA_INC: rd_word = port_data_reg;
         default:                     rd_word = port_data_reg;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         host_data_out <= hpsd_pkg::HPSD_DATA_RST;
         host_data_oe  <= 1'b0;
      end
      else
      begin
         host_data_out <= mux32_mode ? rd_word : {16'h0000, get_half(rd_word, upper)};
         host_data_oe  <= ~internal_strobe_n & dir_r;
      end
   end

   // ==========================================
   // ready: busy only while selected, released the cycle after the synchronised select goes high
   always_ff @(posedge mclk)
   begin
      if (reset)
         wait_ready_n <= 1'b0;
      else if (cs_s)
         wait_ready_n <= 1'b0; // [R3] [R7]
      else
         wait_ready_n <= core_busy & ~internal_strobe_n & is_data; // [R19]
   end
endmodule
`default_nettype wire

// >>> test/hpsd_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checks
module hpsd_sva
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // host side
   input wire logic        port_select_n,
   input wire logic        data_strobe_a,
   input wire logic        data_strobe_b,
   input wire logic        bus_width_strap,
   input wire logic        core_busy,
   input wire logic        wait_ready_n,
   // back end
   input wire logic        mux32_mode,
   input wire logic [31:0] read_addr_reg,
   input wire logic [31:0] write_addr_reg,
   input wire logic        data_wr_pulse,
   input wire logic        data_rd_pulse
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // cycles since a selected strobe was seen, saturating
   logic [3:0] idle_r;
   always_ff @(posedge mclk)
   begin
      if (reset || (!port_select_n && (data_strobe_a ^ data_strobe_b)))
         idle_r <= 4'h0;
      else if (idle_r != 4'hf)
         idle_r <= idle_r + 4'h1;
   end
   a_ready_unselected: assert property (port_select_n [*6] |-> !wait_ready_n)
      else $error("ready not low while deselected");
   a_ready_not_busy: assert property (!core_busy [*4] |-> !wait_ready_n)
      else $error("ready high without busy back end");
   a_ignore_unselected: assert property (port_select_n [*8] |-> !data_wr_pulse && !data_rd_pulse)
      else $error("transfer while deselected");
   a_pulse_has_strobe: assert property (data_wr_pulse || data_rd_pulse |-> idle_r <= 4'ha)
      else $error("transfer without a strobe");
   a_wr_pulse_once: assert property (data_wr_pulse |=> !data_wr_pulse)
      else $error("write pulse longer than one cycle");
   a_dir_exclusive: assert property (!(data_wr_pulse && data_rd_pulse))
      else $error("read and write at once");
   a_addr_pair: assert property (read_addr_reg == write_addr_reg)
      else $error("address registers differ");
   a_strap_taken: assert property ($fell(reset) |=> mux32_mode == $past(bus_width_strap))
      else $error("width strap not captured");
   a_mode_hold: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(mux32_mode))
      else $error("width mode changed");
   c_write: cover property (data_wr_pulse);
   c_read: cover property (data_rd_pulse);
   c_wait: cover property ($rose(wait_ready_n));
endmodule
bind hpsd_top hpsd_sva chk
(
   .mclk(mclk), .reset(reset), .port_select_n(port_select_n), .data_strobe_a(data_strobe_a),
   .data_strobe_b(data_strobe_b), .bus_width_strap(bus_width_strap), .core_busy(core_busy),
   .wait_ready_n(wait_ready_n), .mux32_mode(mux32_mode), .read_addr_reg(read_addr_reg),
   .write_addr_reg(write_addr_reg), .data_wr_pulse(data_wr_pulse), .data_rd_pulse(data_rd_pulse)
);
`default_nettype wire

// >>> test/hpsd_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host processor on the multiplexed bus
module hpsd_host
(
   // clock and answer
   input wire logic        mclk,
   input wire logic        wait_ready_n,
   input wire logic [31:0] host_data_out,
   // pins toward the port
   output logic            port_select_n,
   output logic            data_strobe_a,
   output logic            data_strobe_b,
   output logic [1:0]      access_type_code,
   output logic            rd_wr_dir,
   output logic            halfword_ident,
   output logic [31:0]     host_data_in
);
   int n_stall = 0;
   initial
   begin
      port_select_n = 1'b1;
      data_strobe_a = 1'b1;
      data_strobe_b = 1'b1;
      access_type_code = 2'h0;
      rd_wr_dir = 1'b1;
      halfword_ident = 1'b0;
      host_data_in = 32'h0000_0000;
   end
   // style 0/1: active-low strobe on a/b, 2: active-high on a, 3: select shares strobe a
   task automatic xfer(input logic sel, input logic [1:0] code, input logic dir, input logic id,
                       input logic [31:0] wd, input int style, output logic [31:0] rd);
      int   n;
      logic lv;
      lv = (style != 2);
      @(posedge mclk);
      #1;
      port_select_n = !sel || (style == 3);
      access_type_code = code;
      rd_wr_dir = dir;
      halfword_ident = id;
      host_data_in = wd;
      data_strobe_a = lv;
      data_strobe_b = lv;
      repeat (2) @(posedge mclk);
      #1;
      if (style == 1)
         data_strobe_b = !lv;
      else
         data_strobe_a = !lv;
      if (style == 3)
         port_select_n = !sel;
      n = 0;
      repeat (6) @(posedge mclk);
      #1;
      while (wait_ready_n !== 1'b0 && n < 300)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      // a stall that never ends is reported by the bench
      if (n == 300)
         n_stall++;
      rd = host_data_out;
      data_strobe_a = lv;
      data_strobe_b = lv;
      if (style == 3)
         port_select_n = 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      port_select_n = 1'b1;
      // released lines must not keep looking valid
      host_data_in = ~wd;
      access_type_code = ~code;
      rd_wr_dir = ~dir;
      halfword_ident = ~id;
      repeat (2) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        mclk, reset, strap, core_busy, sel_n, ds_a, ds_b, dir, hid, rdy_n, m32, ord, as_n, oe;
   logic [1:0]  code, c;
   logic [31:0] core_rd_data, din, dout, rdr, wdr, pdr, r, a, d;
   int          n_errors, tests_run, i;
   int          cyc = 0;
   hpsd_top uut
   (
      .mclk(mclk), .reset(reset), .port_select_n(sel_n), .data_strobe_a(ds_a), .data_strobe_b(ds_b),
      .addr_strobe_n(as_n), .access_type_code(code), .rd_wr_dir(dir), .halfword_ident(hid),
      .bus_width_strap(strap), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
      .wait_ready_n(rdy_n), .core_busy(core_busy), .core_rd_data(core_rd_data), .mux32_mode(m32),
      .halfword_order(ord), .read_addr_reg(rdr), .write_addr_reg(wdr), .port_data_reg(pdr),
      .data_wr_pulse(), .data_rd_pulse()
   );
   hpsd_host host
   (
      .mclk(mclk), .wait_ready_n(rdy_n), .host_data_out(dout), .port_select_n(sel_n),
      .data_strobe_a(ds_a), .data_strobe_b(ds_b), .access_type_code(code), .rd_wr_dir(dir),
      .halfword_ident(hid), .host_data_in(din)
   );
   always #5 mclk = ~mclk;
   function automatic logic [31:0] mir(input logic o);
      return {23'h00_0000, o, 7'h00, o};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic do_reset(input logic w);
      #1;
      reset = 1'b1;
      strap = w;
      repeat (8) @(posedge mclk);
      #1;
      reset = 1'b0;
      repeat (6) @(posedge mclk);
   endtask
   // order 0 sends the upper half first
   task automatic w16(input logic [1:0] cc, input logic [31:0] w, input logic o);
      logic [31:0] x;
      host.xfer(1'b1, cc, 1'b0, 1'b0, {16'h0000, o ? w[15:0] : w[31:16]}, 0, x);
      host.xfer(1'b1, cc, 1'b0, 1'b1, {16'h0000, o ? w[31:16] : w[15:0]}, 1, x);
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         test_done();
      end
   end
   initial
   begin
      mclk = 1'b0;
      core_busy = 1'b0;
      as_n = 1'b1;
      core_rd_data = 32'h0000_0000;
      n_errors = 0;
      tests_run = 0;
      void'($urandom(7));
      do_reset(1'b1);
      chk({31'h0, m32}, 32'h0000_0001);
      for (i = 0; i < 2; i++)
      begin
         host.xfer(1'b1, 2'h0, 1'b0, 1'b0, i, i, r);
         chk({31'h0, ord}, i);
         host.xfer(1'b1, 2'h0, 1'b1, 1'b1, 32'h0000_0000, 2, r);
         chk(r & 32'h0000_0101, mir(i[0]));
      end
      // all-ones address so the first increment wraps
      a = 32'hffff_ffff;
      host.xfer(1'b1, 2'h2, 1'b0, 1'b1, a, 0, r);
      chk(rdr, a);
      // released pins now show code 01, read, first half: the address strobe takes them
      core_rd_data = $urandom;
      #1;
      as_n = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      as_n = 1'b1;
      host.xfer(1'b1, 2'h3, 1'b0, 1'b0, 32'h0000_0000, 0, r);
      a = a + hpsd_pkg::HPSD_ADDR_STEP;
      chk(pdr, core_rd_data);
      chk(rdr, a);
      for (i = 0; i < 12; i++)
      begin
         c = (i == 0 || $urandom % 2) ? 2'h1 : 2'h3;
         d = $urandom;
         host.xfer(1'b1, c, 1'b0, i[0], d, $urandom % 4, r);
         if (c == 2'h1)
            a = a + hpsd_pkg::HPSD_ADDR_STEP;
         chk(pdr, d);
         chk(wdr, a);
      end
      core_busy = 1'b1;
      host.xfer(1'b0, 2'h3, 1'b0, 1'b0, ~d, 0, r);
      chk(pdr, d);
      core_rd_data = $urandom;
      fork
         host.xfer(1'b1, 2'h1, 1'b1, 1'b0, 32'h0000_0000, 1, r);
         begin
            repeat (24) @(posedge mclk);
            #1;
            chk({31'h0, rdy_n}, 32'h0000_0001);
            chk({31'h0, oe}, 32'h0000_0001);
            core_busy = 1'b0;
         end
      join
      chk(r, core_rd_data);
      chk(rdr, a + hpsd_pkg::HPSD_ADDR_STEP);
      do_reset(1'b0);
      chk({31'h0, m32}, 32'h0000_0000);
      for (i = 1; i >= 0; i--)
      begin
         host.xfer(1'b1, 2'h0, 1'b0, !i[0], i, 2, r);
         host.xfer(1'b1, 2'h0, 1'b1, i[0], 32'h0000_0000, 0, r);
         chk(r & 32'h0000_0101, mir(i[0]));
         a = $urandom;
         d = $urandom;
         w16(2'h2, a, i[0]);
         chk(wdr, a);
         w16(2'h1, d, i[0]);
         chk(pdr, d);
         chk(wdr, a + hpsd_pkg::HPSD_ADDR_STEP);
      end
      chk(host.n_stall, 32'h0000_0000);
      test_done();
   end
endmodule
`default_nettype wire
